// ### bench/cmd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmd_host_model (
  input  wire logic              clk_i,
  output var  pll_cfg_pkg::cmd_t cmd_o,
  input  wire logic [4:0]        rdata_i,
  input  wire logic              rvalid_i
);
  initial cmd_o = '0;

  // idle address and data are inverted so a late sample never sees the last value
  task automatic release_bus();
    cmd_o.write = 1'b0;
    cmd_o.read  = 1'b0;
    cmd_o.addr  = ~cmd_o.addr;
    cmd_o.wdata = ~cmd_o.wdata;
  endtask

  task automatic write_reg(input logic [2:0] addr, input logic [4:0] data);
    @(negedge clk_i);
    cmd_o.write = 1'b1;
    cmd_o.addr  = addr;
    cmd_o.wdata = data;
    @(negedge clk_i);
    release_bus();
  endtask

  // answer stands right after the taking edge, sampled half a cycle later
  task automatic read_reg(input logic [2:0] addr, output logic [4:0] data, output logic valid);
    @(negedge clk_i);
    cmd_o.read = 1'b1;
    cmd_o.addr = addr;
    @(negedge clk_i);
    // the valid pulse is gone by the next falling edge, so take it here
    valid = rvalid_i;
    data  = rdata_i;
    release_bus();
  endtask
endmodule
`default_nettype wire

// ### bench/dual_pll_config_registers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dual_pll_config_registers_tb_top;
  logic                    clk_i;
  logic                    rst_i;
  logic                    first_lock_i;
  logic                    second_lock_i;
  pll_cfg_pkg::cmd_t       cmd;
  logic [4:0]              rd, k1_f, k2_f, nref;
  logic                    rv, l1en, l2en, m_bad, lock_o;
  logic [3:0]              mode_f, nmul_f;
  logic [5:0]              k1, k2;
  pll_cfg_pkg::driver_en_t drv;
  pll_cfg_pkg::mode_info_t minfo;
  int                      mismatches;
  int                      comparisons;

  pll_cfg_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .first_lock_i(first_lock_i),
    .second_lock_i(second_lock_i), .cmd_rdata_o(rd), .cmd_rvalid_o(rv), .first_loop_enable_o(l1en),
    .second_loop_enable_o(l2en), .mode_code_field_o(mode_f), .input_multiple_field_o(nmul_f),
    .first_output_multiplier_field_o(k1_f), .second_output_multiplier_field_o(k2_f),
    .first_multiple_o(k1), .second_multiple_o(k2), .reference_multiple_o(nref), .driver_en_o(drv),
    .mode_info_o(minfo), .second_multiple_illegal_o(m_bad), .lock_indicator_output_o(lock_o));

  cmd_host_model u_host (.clk_i(clk_i), .cmd_o(cmd), .rdata_i(rd), .rvalid_i(rv));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // derived outputs land one edge after the register, so wait one more cycle
  task automatic wr(input logic [2:0] a, input logic [4:0] d);
    u_host.write_reg(a, d);
    @(negedge clk_i);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [4:0] exp);
    logic [4:0] d;
    logic       v;
    u_host.read_reg(a, d, v);
    check({7'h00, v}, 8'h01);
    check({3'h0, d}, {3'h0, exp});
  endtask

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic t_reset();
    for (int a = 0; a < 5; a++) rd_chk(3'(a), 5'h00);
    check({5'h00, drv}, 8'h00);
    check({2'h0, k1}, 8'h01);
    check({3'h0, nref}, 8'h01);
    check({6'h00, l1en, l2en}, 8'h00);
    check({7'h00, lock_o}, 8'h00);
  endtask

  task automatic t_regs();
    wr(3'h0, {4'h5, 1'b1});
    check({3'h0, mode_f, l1en}, 8'h0B);
    wr(3'h1, {4'hF, 1'b1});
    check({3'h0, nref}, 8'h10);
    check({6'h00, nmul_f == 4'hF, l2en}, 8'h03);
    wr(3'h2, 5'h1F);
    check({2'h0, k1}, 8'h20);
    check({3'h0, k1_f}, 8'h1F);
    wr(3'h3, 5'h1F);
    check({2'h0, k2}, 8'h20);
    check({3'h0, k2_f}, 8'h1F);
    wr(3'h3, 5'h00);
    check({2'h0, k2}, 8'h01);
    rd_chk(3'h0, 5'h0B);
    rd_chk(3'h1, 5'h1F);
    rd_chk(3'h2, 5'h1F);
    for (int i = 2; i < 5; i++) begin
      wr(3'h4, 5'(1 << i));
      check({5'h00, drv}, 8'(1 << (i - 2)));
      rd_chk(3'h4, 5'(1 << i));
    end
    // unmapped place: write must not alias onto a real register
    wr(3'h5, 5'h1F);
    rd_chk(3'h5, 5'h00);
    rd_chk(3'h4, 5'h10);
  endtask

  task automatic t_modes();
    logic [3:0] c;
    logic [4:0] m;
    for (int i = 0; i < 6; i++) begin
      c = 4'(i + i / 3);
      wr(3'h0, {c, 1'b1});
      check({4'h0, minfo.forward_master, minfo.reference_is_e1, minfo.first_is_64k, minfo.second_is_64k},
            {4'h0, 1'b1, c[2], c[1:0] == 2'h2, c[1:0] != 2'h0});
    end
    // a reverse code and a reserved code both fall outside the forward family
    wr(3'h0, {4'h3, 1'b1});
    check({5'h00, minfo.forward_master, minfo.high_speed, minfo.reserved}, 8'h00);
    wr(3'h0, {4'hE, 1'b1});
    check({5'h00, minfo.forward_master, minfo.high_speed, minfo.reserved}, 8'h01);
    wr(3'h0, {4'hD, 1'b1});
    check({7'h00, minfo.high_speed}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      m = (i < 4) ? 5'(1 << i) : 5'((i - 4) * 3);
      wr(3'h3, m);
      check({7'h00, m_bad}, {7'h00, i >= 4});
    end
    // an illegal M only matters in high speed mode
    wr(3'h0, {4'h0, 1'b1});
    check({7'h00, m_bad}, 8'h00);
  endtask

  task automatic t_lock();
    logic [1:0] en;
    logic [1:0] sel;
    logic [1:0] lk;
    logic       exp;
    for (int e = 0; e < 4; e++) begin
      en = 2'(e);
      wr(3'h0, {4'h0, en[0]});
      wr(3'h1, {4'h0, en[1]});
      for (int s = 0; s < 4; s++) begin
        sel = 2'(s);
        wr(3'h4, {3'h7, sel});
        for (int l = 0; l < 4; l++) begin
          lk = 2'(l);
          first_lock_i  = lk[0];
          second_lock_i = lk[1];
          repeat (4) @(negedge clk_i);
          case (sel)
            2'h0: exp = (en != 2'h0) && (!en[0] || lk[0]) && (!en[1] || lk[1]);
            2'h1: exp = lk[1];
            2'h2: exp = lk[0];
            default: exp = 1'b0;
          endcase
          check({7'h00, lock_o}, {7'h00, exp});
        end
      end
    end
  endtask

  initial begin
    rst_i         = 1'b1;
    first_lock_i  = 1'b1;
    second_lock_i = 1'b1;
    mismatches    = 0;
    comparisons   = 0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_regs();
    t_modes();
    t_lock();
    stop_test();
  end

  // whole run needs a few hundred cycles
  initial begin
    #500us;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire

// ### design/level_sync.sv
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // the first stage feeds only the second one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ### design/pll_cfg_pkg.sv
`default_nettype none
package pll_cfg_pkg;

  localparam int REG_W  = 5;
  localparam int ADDR_W = 3;
  localparam int MULT_W = 6;

  // command register offsets
  localparam logic [ADDR_W-1:0] MODE_AND_LOOP1_CONTROL_ADDR           = 3'h0;
  localparam logic [ADDR_W-1:0] INPUT_MULTIPLE_AND_LOOP2_CONTROL_ADDR = 3'h1;
  localparam logic [ADDR_W-1:0] FIRST_OUTPUT_MULTIPLIER_ADDR          = 3'h2;
  localparam logic [ADDR_W-1:0] SECOND_OUTPUT_MULTIPLIER_ADDR         = 3'h3;
  localparam logic [ADDR_W-1:0] OUTPUT_AND_LOCK_CONTROL_ADDR          = 3'h4;

  // reset values
  localparam logic [REG_W-1:0] MODE_AND_LOOP1_CONTROL_RESET           = 5'h00;
  localparam logic [REG_W-1:0] INPUT_MULTIPLE_AND_LOOP2_CONTROL_RESET = 5'h00;
  localparam logic [REG_W-1:0] FIRST_OUTPUT_MULTIPLIER_RESET          = 5'h00;
  localparam logic [REG_W-1:0] SECOND_OUTPUT_MULTIPLIER_RESET         = 5'h00;
  localparam logic [REG_W-1:0] OUTPUT_AND_LOCK_CONTROL_RESET          = 5'h00;
  localparam logic [REG_W-1:0] UNMAPPED_READ_VALUE                    = 5'h00;

  // field positions
  localparam int LOOP_ENABLE_BIT         = 0;
  localparam int UPPER_FIELD_LSB         = 1;
  localparam int UPPER_FIELD_MSB         = 4;
  localparam int FRAME_PULSE_ENABLE_BIT  = 4;
  localparam int FIRST_OUTPUT_ENABLE_BIT = 3;
  localparam int SECOND_OUTPUT_ENABLE_BIT = 2;
  localparam int LOCK_SELECT_MSB         = 1;
  localparam int LOCK_SELECT_LSB         = 0;

  // mode codes of the forward/master family, then high speed and the lowest reserved code
  localparam logic [3:0] MODE_FWD_T1_56_56 = 4'h0;
  localparam logic [3:0] MODE_FWD_T1_56_64 = 4'h1;
  localparam logic [3:0] MODE_FWD_T1_64_64 = 4'h2;
  localparam logic [3:0] MODE_FWD_E1_56_56 = 4'h4;
  localparam logic [3:0] MODE_FWD_E1_56_64 = 4'h5;
  localparam logic [3:0] MODE_FWD_E1_64_64 = 4'h6;
  localparam logic [3:0] MODE_HIGH_SPEED   = 4'hD;
  localparam logic [3:0] MODE_RESERVED_LO  = 4'hE;

  // cycles from a lock pin change to the indicator
  localparam int SYNC_STAGES      = 2;
  localparam int LOCK_PATH_CYCLES = SYNC_STAGES + 1;

  typedef enum logic [1:0] {
    LOCK_BOTH   = 2'b00,
    LOCK_SECOND = 2'b01,
    LOCK_FIRST  = 2'b10,
    LOCK_OFF    = 2'b11
  } lock_sel_t;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } cmd_t;

  typedef struct packed {
    logic frame_pulse;
    logic first_output;
    logic second_output;
  } driver_en_t;

  typedef struct packed {
    logic forward_master;
    logic reference_is_e1;
    logic first_is_64k;
    logic second_is_64k;
    logic high_speed;
    logic reserved;
  } mode_info_t;

endpackage
`default_nettype wire

// ### design/pll_cfg_regs.sv
// Operation
// - second multiplier holds K minus one
// - output bit four enables frame driver
// - output bit three enables first driver
// - output bit two enables second driver
// - select 00 reports enabled loops locked
// - select 01 follows second loop lock
// - select 10 follows first loop lock
// - select 11 holds indicator low
// - forward mode codes pick reference, rates
// - first loop enable bit runs loop one
// - second loop enable bit runs loop two
`timescale 1ns/10ps
`default_nettype none
module pll_cfg_regs (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_i,
  input  wire pll_cfg_pkg::cmd_t                       cmd_i,
  input  wire logic                                    first_lock_i,
  input  wire logic                                    second_lock_i,
  output logic       [pll_cfg_pkg::REG_W-1:0]          cmd_rdata_o,
  output logic                                         cmd_rvalid_o,
  output logic                                         first_loop_enable_o,
  output logic                                         second_loop_enable_o,
  output logic       [3:0]                             mode_code_field_o,
  output logic       [3:0]                             input_multiple_field_o,
  output logic       [pll_cfg_pkg::REG_W-1:0]          first_output_multiplier_field_o,
  output logic       [pll_cfg_pkg::REG_W-1:0]          second_output_multiplier_field_o,
  output logic       [pll_cfg_pkg::MULT_W-1:0]         first_multiple_o,
  output logic       [pll_cfg_pkg::MULT_W-1:0]         second_multiple_o,
  output logic       [4:0]                             reference_multiple_o,
  output pll_cfg_pkg::driver_en_t                      driver_en_o,
  output pll_cfg_pkg::mode_info_t                      mode_info_o,
  output logic                                         second_multiple_illegal_o,
  output logic                                         lock_indicator_output_o
);

  logic [pll_cfg_pkg::REG_W-1:0] mode_and_loop1_control_reg;
  logic [pll_cfg_pkg::REG_W-1:0] input_multiple_and_loop2_control_reg;
  logic [pll_cfg_pkg::REG_W-1:0] first_output_multiplier_reg;
  logic [pll_cfg_pkg::REG_W-1:0] second_output_multiplier_reg;
  logic [pll_cfg_pkg::REG_W-1:0] output_and_lock_control_reg;
  logic [1:0]                    lock_sync;
  logic                          first_lock_s;
  logic                          second_lock_s;
  logic [3:0]                    mode_code;
  pll_cfg_pkg::lock_sel_t        lock_sel;
  logic                          lock_indicator_next;
  logic [pll_cfg_pkg::REG_W-1:0] rdata_next;
  logic                          m_legal;

  // lock states come from the analog loops, outside this clock
  level_sync #(
    .WIDTH (2)
  ) u_lock_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({second_lock_i, first_lock_i}),
    .sync_o  (lock_sync)
  );

  assign first_lock_s  = lock_sync[0];
  assign second_lock_s = lock_sync[1];
  assign mode_code     = mode_and_loop1_control_reg[pll_cfg_pkg::UPPER_FIELD_MSB:pll_cfg_pkg::UPPER_FIELD_LSB];
  assign lock_sel      = pll_cfg_pkg::lock_sel_t'(output_and_lock_control_reg[pll_cfg_pkg::LOCK_SELECT_MSB:
                                                                             pll_cfg_pkg::LOCK_SELECT_LSB]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_and_loop1_control_reg           <= pll_cfg_pkg::MODE_AND_LOOP1_CONTROL_RESET;
      input_multiple_and_loop2_control_reg <= pll_cfg_pkg::INPUT_MULTIPLE_AND_LOOP2_CONTROL_RESET;
      first_output_multiplier_reg          <= pll_cfg_pkg::FIRST_OUTPUT_MULTIPLIER_RESET;
      second_output_multiplier_reg         <= pll_cfg_pkg::SECOND_OUTPUT_MULTIPLIER_RESET;
      output_and_lock_control_reg          <= pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_RESET;
    end else if (cmd_i.write) begin
      // writes to the reserved offsets are dropped
      unique case (cmd_i.addr)
        pll_cfg_pkg::MODE_AND_LOOP1_CONTROL_ADDR:           mode_and_loop1_control_reg           <= cmd_i.wdata;
        pll_cfg_pkg::INPUT_MULTIPLE_AND_LOOP2_CONTROL_ADDR: input_multiple_and_loop2_control_reg <= cmd_i.wdata;
        pll_cfg_pkg::FIRST_OUTPUT_MULTIPLIER_ADDR:          first_output_multiplier_reg          <= cmd_i.wdata;
        pll_cfg_pkg::SECOND_OUTPUT_MULTIPLIER_ADDR:         second_output_multiplier_reg         <= cmd_i.wdata;
        pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR:          output_and_lock_control_reg          <= cmd_i.wdata;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    unique case (cmd_i.addr)
      pll_cfg_pkg::MODE_AND_LOOP1_CONTROL_ADDR:           rdata_next = mode_and_loop1_control_reg;
      pll_cfg_pkg::INPUT_MULTIPLE_AND_LOOP2_CONTROL_ADDR: rdata_next = input_multiple_and_loop2_control_reg;
      pll_cfg_pkg::FIRST_OUTPUT_MULTIPLIER_ADDR:          rdata_next = first_output_multiplier_reg;
      pll_cfg_pkg::SECOND_OUTPUT_MULTIPLIER_ADDR:         rdata_next = second_output_multiplier_reg;
      pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR:          rdata_next = output_and_lock_control_reg;
      default:                                            rdata_next = pll_cfg_pkg::UNMAPPED_READ_VALUE;
    endcase
  end

  // read data is captured one edge after the read and then held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_rdata_o  <= pll_cfg_pkg::UNMAPPED_READ_VALUE;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_i.read;
      if (cmd_i.read) begin
        cmd_rdata_o <= rdata_next;
      end
    end
  end

  // loop enables and multiplier fields, registered copies for the analog side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_loop_enable_o              <= 1'b0;
      second_loop_enable_o             <= 1'b0;
      mode_code_field_o                <= 4'h0;
      input_multiple_field_o           <= 4'h0;
      first_output_multiplier_field_o  <= 5'h00;
      second_output_multiplier_field_o <= 5'h00;
      first_multiple_o                 <= 6'h01;
      second_multiple_o                <= 6'h01;
      reference_multiple_o             <= 5'h01;
    end else begin
      first_loop_enable_o              <= mode_and_loop1_control_reg[pll_cfg_pkg::LOOP_ENABLE_BIT];
      second_loop_enable_o             <= input_multiple_and_loop2_control_reg[pll_cfg_pkg::LOOP_ENABLE_BIT];
      mode_code_field_o                <= mode_code;
      input_multiple_field_o           <= input_multiple_and_loop2_control_reg[pll_cfg_pkg::UPPER_FIELD_MSB:
                                                                               pll_cfg_pkg::UPPER_FIELD_LSB];
      first_output_multiplier_field_o  <= first_output_multiplier_reg;
      second_output_multiplier_field_o <= second_output_multiplier_reg;
      first_multiple_o                 <= {1'b0, first_output_multiplier_reg} + 6'h01;
      second_multiple_o                <= {1'b0, second_output_multiplier_reg} + 6'h01;
      reference_multiple_o             <= {1'b0, input_multiple_and_loop2_control_reg[pll_cfg_pkg::UPPER_FIELD_MSB:
                                                   pll_cfg_pkg::UPPER_FIELD_LSB]} + 5'h01;
    end
  end

  // driver enables, one bit each in the output control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      driver_en_o <= '0;
    end else begin
      driver_en_o.frame_pulse   <= output_and_lock_control_reg[pll_cfg_pkg::FRAME_PULSE_ENABLE_BIT];
      driver_en_o.first_output  <= output_and_lock_control_reg[pll_cfg_pkg::FIRST_OUTPUT_ENABLE_BIT];
      driver_en_o.second_output <= output_and_lock_control_reg[pll_cfg_pkg::SECOND_OUTPUT_ENABLE_BIT];
    end
  end

  // the field value is M itself in high speed mode; flag values the loop cannot make
  assign m_legal = (second_output_multiplier_reg == 5'h01) || (second_output_multiplier_reg == 5'h02) ||
                   (second_output_multiplier_reg == 5'h04) || (second_output_multiplier_reg == 5'h08);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_info_o               <= '0;
      second_multiple_illegal_o <= 1'b0;
    end else begin
      mode_info_o.forward_master  <= (mode_code == pll_cfg_pkg::MODE_FWD_T1_56_56) ||
                                     (mode_code == pll_cfg_pkg::MODE_FWD_T1_56_64) ||
                                     (mode_code == pll_cfg_pkg::MODE_FWD_T1_64_64) ||
                                     (mode_code == pll_cfg_pkg::MODE_FWD_E1_56_56) ||
                                     (mode_code == pll_cfg_pkg::MODE_FWD_E1_56_64) ||
                                     (mode_code == pll_cfg_pkg::MODE_FWD_E1_64_64);
      mode_info_o.reference_is_e1 <= mode_code[2];
      mode_info_o.first_is_64k    <= (mode_code[1:0] == 2'b10);
      mode_info_o.second_is_64k   <= (mode_code[1:0] == 2'b01) || (mode_code[1:0] == 2'b10);
      mode_info_o.high_speed      <= (mode_code == pll_cfg_pkg::MODE_HIGH_SPEED);
      mode_info_o.reserved        <= (mode_code >= pll_cfg_pkg::MODE_RESERVED_LO);
      second_multiple_illegal_o   <= (mode_code == pll_cfg_pkg::MODE_HIGH_SPEED) && !m_legal;
    end
  end

  always_comb begin
    unique case (lock_sel)
      pll_cfg_pkg::LOCK_BOTH: begin
        // a disabled loop does not hold the indicator low; none enabled reads low
        lock_indicator_next = (mode_and_loop1_control_reg[pll_cfg_pkg::LOOP_ENABLE_BIT] ||
                               input_multiple_and_loop2_control_reg[pll_cfg_pkg::LOOP_ENABLE_BIT]) &&
                              (!mode_and_loop1_control_reg[pll_cfg_pkg::LOOP_ENABLE_BIT] || first_lock_s) &&
                              (!input_multiple_and_loop2_control_reg[pll_cfg_pkg::LOOP_ENABLE_BIT] ||
                               second_lock_s);
      end
      pll_cfg_pkg::LOCK_SECOND: lock_indicator_next = second_lock_s;
      pll_cfg_pkg::LOCK_FIRST:  lock_indicator_next = first_lock_s;
      pll_cfg_pkg::LOCK_OFF:    lock_indicator_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_indicator_output_o <= 1'b0;
    end else begin
      lock_indicator_output_o <= lock_indicator_next;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_LOCK_OFF_LOW: assert property (lock_sel == pll_cfg_pkg::LOCK_OFF |=> !lock_indicator_output_o)
    else $error("indicator not low with select 11");

  AST_LOCK_SECOND_ONLY: assert property (lock_sel == pll_cfg_pkg::LOCK_SECOND |=>
                                         lock_indicator_output_o == $past(second_lock_s))
    else $error("indicator does not follow second loop lock");

  AST_LOCK_FIRST_ONLY: assert property (lock_sel == pll_cfg_pkg::LOCK_FIRST |=>
                                        lock_indicator_output_o == $past(first_lock_s))
    else $error("indicator does not follow first loop lock");

  AST_LOCK_BOTH_UNLOCKED: assert property (lock_sel == pll_cfg_pkg::LOCK_BOTH &&
                                           mode_and_loop1_control_reg[0] && !first_lock_s |=> !lock_indicator_output_o)
    else $error("indicator high while enabled first loop unlocked");

  AST_LOCK_PIN_PATH: assert property (lock_sel == pll_cfg_pkg::LOCK_FIRST && first_lock_i
                                      ##1 (lock_sel == pll_cfg_pkg::LOCK_FIRST && $stable(first_lock_i))[*2]
                                      |=> lock_indicator_output_o)
    else $error("first lock did not reach indicator in three cycles");

  AST_FRAME_DRIVER: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR
                                     |=> ##1 driver_en_o.frame_pulse == $past(cmd_i.wdata[4], 2))
    else $error("frame driver enable not bit four of written value");

  AST_FIRST_DRIVER: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR
                                     |=> ##1 driver_en_o.first_output == $past(cmd_i.wdata[3], 2))
    else $error("first driver enable not bit three of written value");

  AST_SECOND_DRIVER: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR
                                      |=> ##1 driver_en_o.second_output == $past(cmd_i.wdata[2], 2))
    else $error("second driver enable not bit two of written value");

  AST_LOOP1_ENABLE: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::MODE_AND_LOOP1_CONTROL_ADDR
                                     |=> ##1 first_loop_enable_o == $past(cmd_i.wdata[0], 2))
    else $error("first loop enable not bit zero of mode register");

  AST_LOOP2_ENABLE: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::INPUT_MULTIPLE_AND_LOOP2_CONTROL_ADDR
                                     |=> ##1 second_loop_enable_o == $past(cmd_i.wdata[0], 2))
    else $error("second loop enable not bit zero of input multiple register");

  AST_SECOND_MULTIPLE: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::SECOND_OUTPUT_MULTIPLIER_ADDR
                                        |=> ##1 second_multiple_o == {1'b0, $past(cmd_i.wdata, 2)} + 6'h01)
    else $error("second multiple is not field plus one");

  AST_REFERENCE_MULTIPLE: assert property (cmd_i.write &&
                                           cmd_i.addr == pll_cfg_pkg::INPUT_MULTIPLE_AND_LOOP2_CONTROL_ADDR
                                           |=> ##1 reference_multiple_o == {1'b0, $past(cmd_i.wdata[4:1], 2)} + 5'h01)
    else $error("reference multiple is not field plus one");

  AST_FORWARD_MODE: assert property (cmd_i.write && cmd_i.addr == pll_cfg_pkg::MODE_AND_LOOP1_CONTROL_ADDR &&
                                     cmd_i.wdata[4:1] == pll_cfg_pkg::MODE_FWD_E1_64_64
                                     |=> ##1 mode_info_o.forward_master && mode_info_o.reference_is_e1 &&
                                     mode_info_o.first_is_64k && mode_info_o.second_is_64k)
    else $error("mode 0110 not decoded as e1 forward 64/64");

  AST_RESET_ZERO: assert property (disable iff (1'b0) rst_i |=> output_and_lock_control_reg == 5'h00 &&
                                   mode_and_loop1_control_reg == 5'h00 && !lock_indicator_output_o)
    else $error("registers not zero after reset");

  COV_BOTH_LOCKED: cover property (lock_sel == pll_cfg_pkg::LOCK_BOTH && mode_and_loop1_control_reg[0] &&
                                   input_multiple_and_loop2_control_reg[0] ##1 lock_indicator_output_o);
  COV_READBACK: cover property (cmd_i.read && cmd_i.addr == pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR ##1 cmd_rvalid_o);
  COV_HIGH_SPEED_BAD_M: cover property (second_multiple_illegal_o);
  COV_UNMAPPED_READ: cover property (cmd_i.read && cmd_i.addr > pll_cfg_pkg::OUTPUT_AND_LOCK_CONTROL_ADDR);

endmodule
`default_nettype wire
